// >>> design/ods_pkg.sv
// package: constants and types for the octal dac serial command decoder
package ods_pkg;
   // channel count and code width
   localparam int N_CH = 8;
   localparam int CODE_W = 10;
   localparam int WORD_W = 16;
   // serial frame edge counts
   localparam logic [4:0] EDGE_EXEC_MIN = 5'h0f;
   localparam logic [4:0] EDGE_MARK_PREV = 5'h0e;
   localparam logic [4:0] EDGE_SAT = 5'h10;
   localparam int CHAIN_TAP = 14;
   // opcodes held in the top nibble of a command word
   localparam logic [3:0] OP_REG_ONLY = 4'h8;
   localparam logic [3:0] OP_WRITE_THRU = 4'h9;
   localparam logic [3:0] OP_UPD_SEL = 4'ha;
   localparam logic [3:0] OP_CH0_WRITE = 4'hb;
   localparam logic [3:0] OP_BROADCAST = 4'hc;
   localparam logic [3:0] OP_PD_HIZ = 4'hd;
   localparam logic [3:0] OP_PD_100K = 4'he;
   localparam logic [3:0] OP_PD_2K5 = 4'hf;
   // bus register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_TERM = 8'h0c;
   localparam logic [2:0] BLK_DATA = 3'h1;
   localparam logic [2:0] BLK_OUT = 3'h2;
   // values after reset
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic MODE_WT_RST = 1'b0;
   // output termination while powered down
   typedef enum logic [1:0] {TERM_NONE, TERM_HIZ, TERM_100K, TERM_2K5} ods_term_t;
   // one command word
   typedef struct packed {
      logic [3:0] opcode_field;
      logic [11:0] payload_field;
   } ods_cmd_t;
   typedef logic [N_CH-1:0][CODE_W-1:0] ods_code_arr_t;
   typedef logic [N_CH-1:0][1:0] ods_term_arr_t;
endpackage

// >>> design/ods_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ods_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // async in, synced out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1; // read by the second stage only
   // reset to zero; the top feeds frame select inverted so that zero reads as idle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// >>> design/ods_frame.sv
// serial frame receiver: shift register, edge counter and chain output
`timescale 1ns/1ps
`default_nettype none
module ods_frame (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // synchronised serial pins (frame select is active low)
   input wire logic sclk_s,
   input wire logic sync_n_s,
   input wire logic din_s,
   // captured command
   output ods_pkg::ods_cmd_t cmd_word,
   output logic cmd_strobe,
   // chain output
   output logic chain_out
);
   import ods_pkg::*;
   logic sclk_d; // previous serial clock sample
   logic sync_d; // previous frame select sample
   logic [WORD_W-1:0] shift; // last sixteen bits received
   logic [4:0] edges; // falling edges this frame, saturating
   logic fall;
   logic rise;
   assign fall = sclk_d & ~sclk_s;
   assign rise = ~sync_d & sync_n_s;
   // edge history; sync reset value high so that reset never looks like a frame end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_d <= 1'b0;
         sync_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         sync_d <= sync_n_s;
      end
   end
   // count falling edges; cleared while frame select is high
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         edges <= '0;
      end else if (sync_n_s) begin
         edges <= '0;
      end else if (fall && edges != EDGE_SAT) begin
         edges <= edges + 5'h01;
      end
   end
   // msb first shift; in a chain the last sixteen bits are this device's word
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         shift <= '0;
      end else if (fall && !sync_n_s) begin
         shift <= {shift[WORD_W-2:0], din_s};
      end
   end
   // chain output: low, a marker high on edge fifteen, then the delayed stream
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chain_out <= 1'b0;
      end else if (sync_n_s) begin
         chain_out <= 1'b0; // idle low between frames
      end else if (fall) begin
         if (edges < EDGE_MARK_PREV) begin
            chain_out <= 1'b0;
         end else if (edges == EDGE_MARK_PREV) begin
            chain_out <= 1'b1;
         end else begin
            chain_out <= shift[CHAIN_TAP];
         end
      end
   end
   // execute on the rising edge of frame select, short frames are dropped
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_strobe <= 1'b0;
         cmd_word <= '0;
      end else begin
         cmd_strobe <= rise && (edges >= EDGE_EXEC_MIN);
         if (rise) begin
            cmd_word <= shift;
         end
      end
   end
endmodule
`default_nettype wire

// >>> design/ods_top.sv
// top: octal dac command decoder with ahb-lite register access
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ods_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial pins
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   output logic chain_out,
   // analog channel control
   output ods_pkg::ods_code_arr_t dac_code,
   output logic [ods_pkg::N_CH-1:0] pd_mask,
   output ods_pkg::ods_term_arr_t term,
   output logic bias_on
);
   import ods_pkg::*;
   logic [2:0] pins_s; // synced sclk, inverted sync_n, din
   ods_cmd_t ser_word; // serial command
   logic ser_strobe; // serial command ready
   logic frame_chain; // chain bit from the receiver
   logic ctrl_en; // serial commands accepted
   logic write_through_mode; // persistent write mode
   ods_cmd_t last_cmd; // most recent executed command
   ods_cmd_t pend_word; // command written over the bus
   logic pend; // bus command waiting
   ods_code_arr_t chreg; // channel data registers
   ods_cmd_t exe_cmd; // command executed this cycle
   logic exe_go;
   logic take_pend;
   logic [N_CH-1:0] reg_m; // registers loaded
   logic [N_CH-1:0] out_m; // outputs loaded
   logic [CODE_W-1:0] new_code;
   logic ap_valid; // data phase of a write pending
   logic [7:0] ap_addr;
   logic [31:0] rd_mux;
   logic rd_take;

   // one-hot channel select
   function automatic logic [N_CH-1:0] onehot(input logic [2:0] sel);
      logic [N_CH-1:0] m;
      m = '0;
      m[sel] = 1'b1;
      return m;
   endfunction

   // which channel registers a command loads
   function automatic logic [N_CH-1:0] regs_of(input ods_cmd_t c);
      logic [N_CH-1:0] m;
      m = '0;
      if (!c.opcode_field[3]) begin
         m = onehot(c.opcode_field[2:0]);
      end else if (c.opcode_field == OP_CH0_WRITE) begin
         m[0] = 1'b1;
      end else if (c.opcode_field == OP_BROADCAST) begin
         m = '1;
      end
      return m;
   endfunction

   // which outputs a command loads
   function automatic logic [N_CH-1:0] outs_of(input ods_cmd_t c, input logic wt);
      logic [N_CH-1:0] m;
      m = '0;
      if (!c.opcode_field[3]) begin
         m = wt ? onehot(c.opcode_field[2:0]) : '0;
      end else if (c.opcode_field == OP_UPD_SEL) begin
         m = c.payload_field[N_CH-1:0];
      end else if (c.opcode_field == OP_CH0_WRITE || c.opcode_field == OP_BROADCAST) begin
         m = '1;
      end
      return m;
   endfunction

   // termination for a power-down opcode
   function automatic ods_term_t term_of(input logic [3:0] op);
      ods_term_t t;
      t = TERM_NONE;
      unique case (op)
         OP_PD_HIZ: t = TERM_HIZ;
         OP_PD_100K: t = TERM_100K;
         OP_PD_2K5: t = TERM_2K5;
         default: t = TERM_NONE;
      endcase
      return t;
   endfunction

   // pins come from the host's domain, two flops before use
   ods_sync #(.W(3)) u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .async_in({sclk, ~sync_n, din}),
      .sync_out(pins_s)
   );

   // frame receiver; select is inverted through the synchroniser so reset reads idle
   ods_frame u_frame (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .sclk_s(pins_s[2]),
      .sync_n_s(~pins_s[1]),
      .din_s(pins_s[0]),
      .cmd_word(ser_word),
      .cmd_strobe(ser_strobe),
      .chain_out(frame_chain)
   );

   // pick the command: serial wins, a bus command waits one more cycle
   always_comb begin
      take_pend = pend && !(ser_strobe && ctrl_en);
      exe_go = (ser_strobe && ctrl_en) || pend;
      exe_cmd = (ser_strobe && ctrl_en) ? ser_word : pend_word;
      reg_m = exe_go ? regs_of(exe_cmd) : '0;
      out_m = exe_go ? outs_of(exe_cmd, write_through_mode) : '0;
      new_code = exe_cmd.payload_field[11:2];
   end

   // chain output straight from a flop at the pin
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chain_out <= 1'b0;
      end else begin
         chain_out <= frame_chain;
      end
   end

   // persistent write mode; only the two mode opcodes change it, every other command leaves it alone
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         write_through_mode <= MODE_WT_RST;
      end else if (exe_go && exe_cmd.opcode_field == OP_WRITE_THRU) begin
         write_through_mode <= 1'b1;
      end else if (exe_go && exe_cmd.opcode_field == OP_REG_ONLY) begin
         write_through_mode <= 1'b0;
      end
   end

   // channel data registers, cleared at power-on and untouched by power-down
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chreg <= '0;
      end else begin
         for (int i = 0; i < N_CH; i++) begin
            if (reg_m[i]) begin
               chreg[i] <= new_code;
            end
         end
      end
   end

   // outputs: fresh code for loaded registers, stored code otherwise, all in one edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dac_code <= '0;
      end else begin
         for (int i = 0; i < N_CH; i++) begin
            if (out_m[i]) begin
               dac_code[i] <= reg_m[i] ? new_code : chreg[i];
            end
         end
      end
   end

   // power-down flags and terminations; an output update wakes the channel
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pd_mask <= '0;
         term <= '0;
      end else begin
         for (int i = 0; i < N_CH; i++) begin
            if (exe_go && term_of(exe_cmd.opcode_field) != TERM_NONE
                && exe_cmd.payload_field[i]) begin
               pd_mask[i] <= 1'b1;
               term[i] <= term_of(exe_cmd.opcode_field);
            end else if (out_m[i]) begin
               pd_mask[i] <= 1'b0;
               term[i] <= TERM_NONE;
            end
         end
      end
   end

   // bias follows the power-down flags one cycle later
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bias_on <= 1'b1;
      end else begin
         bias_on <= ~&pd_mask;
      end
   end

   // last executed command for software
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         last_cmd <= '0;
      end else if (exe_go) begin
         last_cmd <= exe_cmd;
      end
   end

   // ahb address phase: capture writes for their data phase
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ap_valid <= 1'b0;
         ap_addr <= '0;
      end else if (hready) begin
         ap_valid <= hsel && htrans[1] && hwrite;
         ap_addr <= haddr[7:0];
      end
   end

   // bus command register and control; a new write beats the clear of pend
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_en <= CTRL_EN_RST;
         pend <= 1'b0;
         pend_word <= '0;
      end else begin
         if (ap_valid && ap_addr == OFS_CTRL) begin
            ctrl_en <= hwdata[0];
         end
         if (ap_valid && ap_addr == OFS_CMD) begin
            pend <= 1'b1;
            pend_word <= hwdata[WORD_W-1:0];
         end else if (take_pend) begin
            pend <= 1'b0;
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = '0;
      rd_take = hsel && htrans[1] && !hwrite && hready;
      if (haddr[7:5] == BLK_DATA) begin
         rd_mux[CODE_W-1:0] = chreg[haddr[4:2]];
      end else if (haddr[7:5] == BLK_OUT) begin
         rd_mux[CODE_W-1:0] = dac_code[haddr[4:2]];
      end else begin
         unique case (haddr[7:0])
            OFS_CTRL: rd_mux[0] = ctrl_en;
            OFS_CMD: rd_mux[WORD_W-1:0] = pend_word;
            OFS_STATUS: rd_mux = {last_cmd, pd_mask, 5'h00, pend, bias_on,
                                  write_through_mode};
            OFS_TERM: rd_mux[2*N_CH-1:0] = term;
            default: rd_mux = '0;
         endcase
      end
   end

   // zero-wait answer: read data registered at the address phase
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= rd_take ? rd_mux : '0;
      end
   end
endmodule
`default_nettype wire

// >>> verif/ods_top_assertions.sv
// checker: port-level properties of the octal dac command decoder
`timescale 1ns/1ps
`default_nettype none
module ods_top_assertions (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bus side
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // serial and channel side
   input wire logic sync_n,
   input wire logic chain_out,
   input wire ods_pkg::ods_code_arr_t dac_code,
   input wire logic [ods_pkg::N_CH-1:0] pd_mask,
   input wire ods_pkg::ods_term_arr_t term,
   input wire logic bias_on
);
   import ods_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // zero wait states, always okay
   bus_ready_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   // read data only in the cycle after a read address phase
   rdata_idle_a: assert property (!$past(hsel && htrans[1] && hready && !hwrite)
      |-> hrdata == 32'h0) else $error("read data outside a read");
   // bias follows the power-down set one cycle later
   bias_gate_a: assert property (bias_on == !(&$past(pd_mask)))
      else $error("bias generator level wrong");
   // a termination is shown exactly for powered-down channels
   for (genvar i = 0; i < N_CH; i++) begin : g_ch
      pd_term_a: assert property (pd_mask[i] == (term[i] != 2'h0))
         else $error("termination and power-down disagree");
   end
   // chain output rests low while the frame select is high
   chain_idle_a: assert property (sync_n [*6] |-> !chain_out)
      else $error("chain output active between frames");
   // nothing executes while a frame is still open
   frame_hold_a: assert property ((!sync_n && !hsel) [*8] |->
      $stable(dac_code) && $stable(pd_mask))
      else $error("outputs moved inside a frame");
   // first edge after release still shows the cleared state
   reset_clear_a: assert property (!$past(nrst) |-> dac_code == '0 &&
      pd_mask == 8'h00 && term == '0 && !chain_out && bias_on)
      else $error("outputs not cleared by reset");
endmodule
bind ods_top ods_top_assertions chk (.sys_clk, .nrst, .hsel, .htrans, .hwrite, .hready,
   .hrdata, .hreadyout, .hresp, .sync_n, .chain_out, .dac_code, .pd_mask, .term, .bias_on);
`default_nettype wire

// >>> verif/ods_host_model.sv
// partner model: serial host that frames commands and samples the chain output
`timescale 1ns/1ps
`default_nettype none
module ods_host_model (
   // serial pins toward the device
   output logic sclk,
   output logic sync_n,
   output logic din,
   // chain output from the device
   input wire logic chain_out
);
   logic [30:0] cap; // chain samples after edges one to thirty-one
   // idle: select high, data low, clock parked low to save power
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b0;
   end
   // 200 ns bit period, far below the chained limit; n bits, msb first
   task automatic send(input logic [31:0] w, input int n);
      #5; // step off the bench clock's edges so pins never change as they are sampled
      sync_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         sclk = 1'b1;
         #100;
         // sampled late so the synchroniser delay has settled
         cap = {cap[29:0], chain_out};
         sclk = 1'b0;
         #100;
      end
      // select rises in the half period after the last fall
      sync_n = 1'b1;
      din = 1'b0;
      #150;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// testbench: serial and bus stimulus against tracked expectations
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ods_pkg::*;
   logic sys_clk = 1'b0; // bench clock
   logic nrst = 1'b0; // active-low reset
   logic hsel = 1'b0; // bus select
   logic hwrite = 1'b0; // bus direction
   logic [1:0] htrans = 2'b00; // bus transfer kind
   logic [31:0] haddr = 32'h0; // bus address
   logic [31:0] hwdata = 32'h0; // bus write data
   logic [31:0] hrdata; // bus read data
   logic hreadyout, hresp, hready, sclk, sync_n, din, chain_out; // handshake and pins
   ods_code_arr_t dac_code; // output codes
   logic [N_CH-1:0] pd_mask; // powered-down set
   ods_term_arr_t term; // terminations
   logic bias_on; // bias generator
   logic [9:0] e_reg [N_CH]; // expected data registers
   logic [9:0] e_out [N_CH]; // expected outputs
   logic [1:0] e_term [N_CH]; // expected terminations
   logic [7:0] e_pd = 8'h00; // expected power-down set
   logic e_wt = 1'b0; // expected write-through flag
   logic [31:0] rd; // read-back scratch
   int seed, bad_count, checks; // seed and counters
   // hand-picked corners: every opcode except channel writes 2 to 5, both modes, all down then wake
   logic [15:0] corner [13] = '{16'h8000, 16'h0ffc, 16'h7ab4, 16'h1c00, 16'ha003,
      16'h9000, 16'h6800, 16'hd0ff, 16'hbfff, 16'he0f0, 16'hf30c, 16'hc404, 16'h8000};
   assign hready = hreadyout;
   initial forever #12.5 sys_clk = ~sys_clk;
   // clock and select shared, chain output read back by the host
   ods_host_model host (.sclk, .sync_n, .din, .chain_out);
   ods_top dut (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .sclk, .sync_n, .din, .chain_out, .dac_code,
      .pd_mask, .term, .bias_on);
   initial foreach (e_reg[i]) {e_reg[i], e_out[i], e_term[i]} = '0;
   // an output load wakes the channel
   function automatic void wake(input int i, input logic [9:0] v);
      e_out[i] = v;
      e_pd[i] = 1'b0;
      e_term[i] = 2'h0;
   endfunction
   // expected effect of one executed command word
   function automatic void apply(input logic [15:0] w);
      logic [9:0] c;
      c = w[11:2];
      for (int i = 0; i < N_CH; i++) begin
         if (!w[15] && w[14:12] == i) begin
            e_reg[i] = c;
            if (e_wt) wake(i, c);
         end
         if (w[15:12] == OP_UPD_SEL && w[i]) wake(i, e_reg[i]);
         if (w[15:12] == OP_CH0_WRITE) begin
            if (i == 0) e_reg[0] = c;
            wake(i, e_reg[i]);
         end
         if (w[15:12] == OP_BROADCAST) begin
            e_reg[i] = c;
            wake(i, c);
         end
         if (w[15:12] >= OP_PD_HIZ && w[i]) begin
            e_pd[i] = 1'b1;
            e_term[i] = w[13:12];
         end
      end
      if (w[15:12] == OP_REG_ONLY) e_wt = 1'b0;
      if (w[15:12] == OP_WRITE_THRU) e_wt = 1'b1;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one bus phase: ready and read data are taken at the same rising edge
   task automatic wait_ready(output logic [31:0] d);
      logic ok;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         ok = hreadyout;
         d = hrdata;
         n++;
      end while (ok !== 1'b1 && n < 20);
      if (ok !== 1'b1) begin
         bad_count++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready(rd);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready(rd);
   endtask
   // outputs, registers and mode against the tracked expectation
   task automatic compare_all();
      logic [15:0] tv; // expected termination word
      for (int i = 0; i < N_CH; i++) begin
         tv[2*i +: 2] = e_term[i];
         check({dac_code[i], term[i], pd_mask[i]}, {e_out[i], e_term[i], e_pd[i]});
         bus(1'b0, 8'h20 + 8'(4 * i), 32'h0);
         check(rd, {22'h0, e_reg[i]});
         bus(1'b0, 8'h40 + 8'(4 * i), 32'h0);
         check(rd, {22'h0, e_out[i]});
      end
      check(bias_on, !(&e_pd));
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rd[0], e_wt);
      check(rd[15:0], {e_pd, 5'h00, 1'b0, !(&e_pd), e_wt});
      bus(1'b0, OFS_TERM, 32'h0);
      check(rd, {16'h0, tv});
   endtask
   task automatic cmd(input logic [31:0] w, input int n, input logic take);
      host.send(w, n);
      repeat (12) @(posedge sys_clk);
      if (take) apply(w[15:0]);
      compare_all();
   endtask
   initial begin
      seed = 41;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      compare_all();
      foreach (corner[k]) cmd({16'h0, corner[k]}, 16, 1'b1);
      repeat (30) cmd({16'h0, 16'($random(seed))}, 16, 1'b1);
      cmd(32'h9abc, 14, 1'b0);
      // two words in one frame: last word executes, first comes out
      cmd({16'h3ffc, 16'h5a5c}, 32, 1'b1);
      check(host.cap, {14'h0, 1'b1, 16'h3ffc});
      // fifteen edges still execute; the missing top bit is the zero left from the last word
      cmd(32'h1c00, 15, 1'b1);
      bus(1'b1, OFS_CTRL, 32'h0);
      cmd(32'hc3fc, 16, 1'b0);
      bus(1'b1, OFS_CTRL, 32'h1);
      bus(1'b1, OFS_CMD, 32'hc804);
      repeat (6) @(posedge sys_clk);
      apply(16'hc804);
      compare_all();
      bus(1'b0, 8'h80, 32'h0);
      check(rd, 32'h0);
      // second reset in mid-run: everything back to the power-on state
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      foreach (e_reg[i]) {e_reg[i], e_out[i], e_term[i]} = '0;
      e_pd = 8'h00;
      e_wt = 1'b0;
      compare_all();
      give_verdict();
   end
endmodule
`default_nettype wire
